/* File: include/trim_bank_regs.svh */
// trim register bank: offsets, field positions, reset and response codes
// assumes AXI4-Lite byte addressing; a register's byte address is its
// printed index times four
`ifndef TRIM_BANK_REGS_SVH
`define TRIM_BANK_REGS_SVH

// register indices as printed; byte address = index * 4
`define TRIM_IDX_OFS_A_IN1   12'h348
`define TRIM_IDX_OFS_A_IN2   12'h34A
`define TRIM_IDX_OFS_B_IN1   12'h34C
`define TRIM_IDX_OFS_B_IN2   12'h34E
`define TRIM_IDX_FINE_GAIN_TRIM_BANK_ZERO     12'h360
`define TRIM_IDX_FINE_GAIN_TRIM_BANK_ONE     12'h361
`define TRIM_IDX_FINE_GAIN_TRIM_BANK_FOUR     12'h364
`define TRIM_IDX_STATUS      12'h370

// storage slots, also the fuse store word numbers
`define TRIM_SLOT_OFS_A_IN1  3'h0
`define TRIM_SLOT_OFS_A_IN2  3'h1
`define TRIM_SLOT_OFS_B_IN1  3'h2
`define TRIM_SLOT_OFS_B_IN2  3'h3
`define TRIM_SLOT_FINE_GAIN_TRIM_BANK_ZERO    3'h4
`define TRIM_SLOT_FINE_GAIN_TRIM_BANK_ONE    3'h5
`define TRIM_SLOT_FINE_GAIN_TRIM_BANK_FOUR    3'h6
`define TRIM_SLOT_STATUS     3'h7
`define TRIM_NUM_SLOTS       7
`define TRIM_WORD_ADDR_W     12

// field layout
`define TRIM_OFS_MSB         11
`define TRIM_OFS_LSB         0
`define TRIM_GAIN_MSB        4
`define TRIM_GAIN_LSB        0
`define TRIM_LOW_BYTE_MSB    7
`define TRIM_HIGH_BYTE_LSB   8
`define TRIM_STAT_DONE_BIT   0
`define TRIM_STAT_BUSY_BIT   1

// masks of implemented bits, reset and response codes
`define TRIM_WIDE_MASK       16'hFFFF
`define TRIM_NARROW_MASK     16'h00FF
`define TRIM_CLEAR_WORD      16'h0000
`define TRIM_CLEAR_OFS       12'h000
`define TRIM_CLEAR_GAIN      5'h00
`define TRIM_CLEAR_BUS       32'h0000_0000
`define TRIM_RESP_OKAY       2'h0
`define TRIM_RESP_SLVERR     2'h2

`endif

/* File: include/trim_bank_pkg.sv */
// trim register bank: shared types
// assumes trim_bank_regs.svh for numeric constants
package trim_bank_pkg;

  typedef logic [2:0]  slot_idx_t;
  typedef logic [15:0] trim_word_t;

  // fuse loader sequencing, one-hot
  typedef enum logic [2:0] {
    LD_REQ     = 3'b001,
    LD_CAPTURE = 3'b010,
    LD_DONE    = 3'b100
  } loader_state_t;

  // operating point from the calibration engine
  typedef struct packed {
    logic fg_cal_en;
    logic core_a_second_input;
    logic core_a_quad_phase;
    logic core_b_second_input;
    logic core_b_quad_phase;
  } cal_select_t;

  // trims applied to the converter cores
  typedef struct packed {
    logic [11:0] core_a_offset;
    logic        core_a_offset_valid;
    logic [11:0] core_b_offset;
    logic        core_b_offset_valid;
    logic [4:0]  gain_bank_zero;
    logic [4:0]  gain_bank_one;
    logic [4:0]  gain_bank_four;
  } trim_apply_t;

  // read request to the fuse store
  typedef struct packed {
    logic      en;
    slot_idx_t idx;
  } fuse_req_t;

  // one fuse word headed for a trim slot
  typedef struct packed {
    logic       load;
    slot_idx_t  idx;
    trim_word_t data;
  } fuse_load_t;

endpackage

/* File: hw/trim_fuse_loader.sv */
// trim register bank: fuse store sequencer
// assumes a fuse store on CORE_CLK answering a read one cycle later
`timescale 1ns/100ps

`include "trim_bank_regs.svh"

module trim_fuse_loader #(
  parameter int NUM_SLOTS = `TRIM_NUM_SLOTS
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  output trim_bank_pkg::fuse_req_t     fuse_req,
  input  wire trim_bank_pkg::trim_word_t fuse_data,
  output trim_bank_pkg::fuse_load_t    load,
  output logic                         done
);

  trim_bank_pkg::loader_state_t state;
  trim_bank_pkg::slot_idx_t     idx;

  initial begin
    if (NUM_SLOTS < 1 || NUM_SLOTS > 7) begin
      $error("trim_fuse_loader: NUM_SLOTS out of range");
    end
  end

  // walk every slot once after reset: request, then capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= trim_bank_pkg::LD_REQ;
      idx   <= `TRIM_SLOT_OFS_A_IN1;
    end else begin
      case (state)
        trim_bank_pkg::LD_REQ: begin
          state <= trim_bank_pkg::LD_CAPTURE;
        end
        trim_bank_pkg::LD_CAPTURE: begin
          if (idx == 3'(NUM_SLOTS - 1)) begin
            state <= trim_bank_pkg::LD_DONE;
          end else begin
            idx   <= idx + 3'h1;
            state <= trim_bank_pkg::LD_REQ;
          end
        end
        trim_bank_pkg::LD_DONE: begin
          state <= trim_bank_pkg::LD_DONE;
        end
        default: begin
          state <= trim_bank_pkg::LD_REQ;
        end
      endcase
    end
  end

  // request and capture strobes
  assign fuse_req.en  = (state == trim_bank_pkg::LD_REQ);
  assign fuse_req.idx = idx;
  assign load.load    = (state == trim_bank_pkg::LD_CAPTURE);
  assign load.idx     = idx;
  assign load.data    = fuse_data;
  assign done         = (state == trim_bank_pkg::LD_DONE);

endmodule // trim_fuse_loader

/* File: hw/core_trim_register_bank.sv */
// trim register bank for a dual-core interleaved converter: offset and
// fine gain trims behind an AXI4-Lite slave, seeded from a fuse store
// assumes calibration selects and fuse data arrive on CORE_CLK
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps

`include "trim_bank_regs.svh"

module core_trim_register_bank #(
  parameter int ADDR_W = 14
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RESET_N,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]         S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]         S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  // calibration engine and converter cores
  input  wire trim_bank_pkg::cal_select_t CAL_SELECT,
  output trim_bank_pkg::trim_apply_t     TRIM_APPLY,
  // fuse store
  output trim_bank_pkg::fuse_req_t       FUSE_REQ,
  input  wire trim_bank_pkg::trim_word_t FUSE_DATA,
  output logic                           LOAD_DONE
);

  localparam int SLOTS = `TRIM_NUM_SLOTS;

  // trim storage, one 16-bit word per slot
  trim_bank_pkg::trim_word_t  trim_reg [SLOTS];

  // fuse loader hookup
  trim_bank_pkg::fuse_load_t  fuse_load;
  logic                       load_done;

  // write channel holding registers
  logic                       aw_held;
  logic [ADDR_W-1:0]          aw_addr;
  logic                       w_held;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       wr_fire;
  logic                       wr_hit;
  trim_bank_pkg::slot_idx_t   wr_slot;

  // read channel
  logic                       ar_fire;
  logic                       rd_hit;
  trim_bank_pkg::slot_idx_t   rd_slot;
  logic [31:0]                next_rdata;

  initial begin
    if (ADDR_W < `TRIM_WORD_ADDR_W + 2 || ADDR_W > 32) begin
      $error("core_trim_register_bank: ADDR_W must be 14 to 32");
    end
  end

  // printed index of each slot
  function automatic logic [11:0] slot_index(
    input trim_bank_pkg::slot_idx_t s
  );
    case (s)
      `TRIM_SLOT_OFS_A_IN1: slot_index = `TRIM_IDX_OFS_A_IN1;
      `TRIM_SLOT_OFS_A_IN2: slot_index = `TRIM_IDX_OFS_A_IN2;
      `TRIM_SLOT_OFS_B_IN1: slot_index = `TRIM_IDX_OFS_B_IN1;
      `TRIM_SLOT_OFS_B_IN2: slot_index = `TRIM_IDX_OFS_B_IN2;
      `TRIM_SLOT_FINE_GAIN_TRIM_BANK_ZERO:   slot_index = `TRIM_IDX_FINE_GAIN_TRIM_BANK_ZERO;
      `TRIM_SLOT_FINE_GAIN_TRIM_BANK_ONE:   slot_index = `TRIM_IDX_FINE_GAIN_TRIM_BANK_ONE;
      `TRIM_SLOT_FINE_GAIN_TRIM_BANK_FOUR:   slot_index = `TRIM_IDX_FINE_GAIN_TRIM_BANK_FOUR;
      default:              slot_index = `TRIM_IDX_STATUS;
    endcase
  endfunction

  // implemented bits of a slot: offsets 16 bits, gains 8 bits
  function automatic trim_bank_pkg::trim_word_t slot_mask(
    input trim_bank_pkg::slot_idx_t s
  );
    if (s < `TRIM_SLOT_FINE_GAIN_TRIM_BANK_ZERO) begin
      slot_mask = `TRIM_WIDE_MASK;
    end else begin
      slot_mask = `TRIM_NARROW_MASK;
    end
  endfunction

  // byte address to slot; a miss on unaligned or unmapped addresses
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] word;
    decode = {1'b0, `TRIM_SLOT_STATUS};
    word   = a >> 2;
    if (a[1:0] == 2'h0) begin
      for (int i = 0; i <= SLOTS; i++) begin
        if (word == ADDR_W'(slot_index(3'(i)))) begin
          decode = {1'b1, 3'(i)};
        end
      end
    end
  endfunction

  // fuse store sequencer; the bus stalls until it finishes
  trim_fuse_loader #(
    .NUM_SLOTS (SLOTS)
  ) u_loader (
    .clk       (CORE_CLK),
    .reset_n   (RESET_N),
    .fuse_req  (FUSE_REQ),
    .fuse_data (FUSE_DATA),
    .load      (fuse_load),
    .done      (load_done)
  );

  assign LOAD_DONE = load_done;

  // channel ready terms, all closed while the fuse load runs
  assign S_AXI_AWREADY = load_done && !aw_held;
  assign S_AXI_WREADY  = load_done && !w_held;
  assign S_AXI_ARREADY = load_done && !S_AXI_RVALID;

  // a write executes once address and data are both held
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign {wr_hit, wr_slot} = decode(aw_addr);
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign {rd_hit, rd_slot} = decode(S_AXI_ARADDR);

  // capture write address, either order against data
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // capture write data and strobes
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      w_held <= 1'b0;
      w_data <= `TRIM_CLEAR_BUS;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // write response; unmapped or unaligned gets SLVERR
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `TRIM_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? `TRIM_RESP_OKAY : `TRIM_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // trim storage: fuse load, then byte-lane writes from the bus
  for (genvar g = 0; g < SLOTS; g++) begin : g_slot
    localparam trim_bank_pkg::slot_idx_t SLOT = 3'(g);
    trim_bank_pkg::trim_word_t lane_mask;
    trim_bank_pkg::trim_word_t next_word;

    // reserved bits are stored like the field bits
    always_comb begin
      lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}} & slot_mask(SLOT);
      next_word = (trim_reg[g] & ~lane_mask)
                | (w_data[15:0] & lane_mask);
    end

    always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
        trim_reg[g] <= `TRIM_CLEAR_WORD;
      end else if (fuse_load.load && fuse_load.idx == SLOT) begin
        trim_reg[g] <= fuse_load.data & slot_mask(SLOT);
      end else if (wr_fire && wr_hit && wr_slot == SLOT) begin
        trim_reg[g] <= next_word;
      end
    end
  end

  // read value of a decoded slot, upper bits zero
  always_comb begin
    next_rdata = `TRIM_CLEAR_BUS;
    if (rd_slot == `TRIM_SLOT_STATUS) begin
      next_rdata[`TRIM_STAT_DONE_BIT] = load_done;
      next_rdata[`TRIM_STAT_BUSY_BIT] = !load_done;
    end else begin
      next_rdata[15:0] = trim_reg[rd_slot] & slot_mask(rd_slot);
    end
  end

  // read data channel, one read outstanding
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= `TRIM_CLEAR_BUS;
      S_AXI_RRESP  <= `TRIM_RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_hit ? next_rdata : `TRIM_CLEAR_BUS;
      S_AXI_RRESP  <= rd_hit ? `TRIM_RESP_OKAY : `TRIM_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // core A offset: foreground calibration on the 90 degree phase
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      TRIM_APPLY.core_a_offset       <= `TRIM_CLEAR_OFS;
      TRIM_APPLY.core_a_offset_valid <= 1'b0;
    end else if (load_done && CAL_SELECT.fg_cal_en
                 && CAL_SELECT.core_a_quad_phase) begin
      TRIM_APPLY.core_a_offset_valid <= 1'b1;
      if (CAL_SELECT.core_a_second_input) begin
        TRIM_APPLY.core_a_offset <= trim_reg[`TRIM_SLOT_OFS_A_IN2]
                                    [`TRIM_OFS_MSB:`TRIM_OFS_LSB];
      end else begin
        TRIM_APPLY.core_a_offset <= trim_reg[`TRIM_SLOT_OFS_A_IN1]
                                    [`TRIM_OFS_MSB:`TRIM_OFS_LSB];
      end
    end else begin
      TRIM_APPLY.core_a_offset       <= `TRIM_CLEAR_OFS;
      TRIM_APPLY.core_a_offset_valid <= 1'b0;
    end
  end

  // core B offset: foreground calibration on the 0 degree phase
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      TRIM_APPLY.core_b_offset       <= `TRIM_CLEAR_OFS;
      TRIM_APPLY.core_b_offset_valid <= 1'b0;
    end else if (load_done && CAL_SELECT.fg_cal_en
                 && !CAL_SELECT.core_b_quad_phase) begin
      TRIM_APPLY.core_b_offset_valid <= 1'b1;
      if (CAL_SELECT.core_b_second_input) begin
        TRIM_APPLY.core_b_offset <= trim_reg[`TRIM_SLOT_OFS_B_IN2]
                                    [`TRIM_OFS_MSB:`TRIM_OFS_LSB];
      end else begin
        TRIM_APPLY.core_b_offset <= trim_reg[`TRIM_SLOT_OFS_B_IN1]
                                    [`TRIM_OFS_MSB:`TRIM_OFS_LSB];
      end
    end else begin
      TRIM_APPLY.core_b_offset       <= `TRIM_CLEAR_OFS;
      TRIM_APPLY.core_b_offset_valid <= 1'b0;
    end
  end

  // fine gain trims, reserved bits 7-5 not applied
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      TRIM_APPLY.gain_bank_zero <= `TRIM_CLEAR_GAIN;
      TRIM_APPLY.gain_bank_one  <= `TRIM_CLEAR_GAIN;
      TRIM_APPLY.gain_bank_four <= `TRIM_CLEAR_GAIN;
    end else begin
      TRIM_APPLY.gain_bank_zero <= trim_reg[`TRIM_SLOT_FINE_GAIN_TRIM_BANK_ZERO]
                                   [`TRIM_GAIN_MSB:`TRIM_GAIN_LSB];
      TRIM_APPLY.gain_bank_one  <= trim_reg[`TRIM_SLOT_FINE_GAIN_TRIM_BANK_ONE]
                                   [`TRIM_GAIN_MSB:`TRIM_GAIN_LSB];
      TRIM_APPLY.gain_bank_four <= trim_reg[`TRIM_SLOT_FINE_GAIN_TRIM_BANK_FOUR]
                                   [`TRIM_GAIN_MSB:`TRIM_GAIN_LSB];
    end
  end

endmodule // core_trim_register_bank

/* File: testbench/trim_bank_chk.sv */
// trim bank checker: bus lockout, handshakes and trim apply timing
// assumes binding onto core_trim_register_bank, one clock domain
`timescale 1ns/100ps

module trim_bank_chk (
  input wire logic                       CORE_CLK,
  input wire logic                       RESET_N,
  input wire logic                       S_AXI_AWREADY,
  input wire logic                       S_AXI_WREADY,
  input wire logic                       S_AXI_BVALID,
  input wire logic                       S_AXI_BREADY,
  input wire logic                       S_AXI_ARREADY,
  input wire logic [31:0]                S_AXI_RDATA,
  input wire logic                       S_AXI_RVALID,
  input wire logic                       S_AXI_RREADY,
  input wire trim_bank_pkg::cal_select_t CAL_SELECT,
  input wire trim_bank_pkg::trim_apply_t TRIM_APPLY,
  input wire logic                       LOAD_DONE
);
  default clocking dclk @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // fuse load runs first, bus shut until it ends
  property p_bus_locked;
    !LOAD_DONE |-> !(S_AXI_AWREADY || S_AXI_WREADY || S_AXI_ARREADY);
  endproperty
  a_bus_locked: assert property (p_bus_locked)
    else $error("bus open during fuse load");
  property p_load_time;
    $rose(RESET_N) |-> !LOAD_DONE [*8] ##[2:10] LOAD_DONE;
  endproperty
  a_load_time: assert property (p_load_time)
    else $error("fuse load length off");

  // offset valid flags follow the operating point one cycle later
  property p_a_valid;
    LOAD_DONE && CAL_SELECT.fg_cal_en && CAL_SELECT.core_a_quad_phase
      |=> TRIM_APPLY.core_a_offset_valid;
  endproperty
  a_a_valid: assert property (p_a_valid)
    else $error("core a offset not applied");
  property p_b_valid;
    CAL_SELECT.fg_cal_en && !CAL_SELECT.core_b_quad_phase
      |=> TRIM_APPLY.core_b_offset_valid == $past(LOAD_DONE);
  endproperty
  a_b_valid: assert property (p_b_valid)
    else $error("core b offset valid wrong");
  property p_a_zero;
    !CAL_SELECT.fg_cal_en |=> !TRIM_APPLY.core_a_offset_valid
      && TRIM_APPLY.core_a_offset == 12'h000;
  endproperty
  a_a_zero: assert property (p_a_zero)
    else $error("core a offset outside calibration");

  // once the fuse load is done, bank one gain only moves after a completed write
  property p_gain_cause;
    $changed(TRIM_APPLY.gain_bank_one) && $past(LOAD_DONE, 4)
      |-> $past(S_AXI_BVALID);
  endproperty
  a_gain_cause: assert property (p_gain_cause)
    else $error("gain moved without a write");

  // responses hold until taken
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");

  // main scenarios reached
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_core_a: cover property (TRIM_APPLY.core_a_offset_valid);
  c_core_b: cover property (TRIM_APPLY.core_b_offset_valid);
endmodule // trim_bank_chk

bind core_trim_register_bank trim_bank_chk i_chk (.*);

/* File: testbench/core_trim_register_bank_bench.sv */
// trim bank bench: register table, trim apply, reset reload
// assumes the fuse store is modelled here, one word per request
`timescale 1ns/100ps
`include "trim_bank_regs.svh"

module core_trim_register_bank_bench;
  typedef struct {
    logic [13:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] rd;
    logic [1:0]  rs;
  } row_t;
  logic        CORE_CLK = 1'b0, RESET_N = 1'b0;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_BREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, LOAD_DONE;
  logic [13:0] S_AXI_AWADDR = 14'h0000, S_AXI_ARADDR = 14'h0000;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'h0;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  trim_bank_pkg::cal_select_t CAL_SELECT = 5'h00;
  trim_bank_pkg::trim_apply_t TRIM_APPLY;
  trim_bank_pkg::fuse_req_t   FUSE_REQ;
  trim_bank_pkg::trim_word_t  FUSE_DATA = 16'h0000;
  int          n_errors = 0, check_count = 0;
  logic [15:0] fuse [8] = '{16'hA123, 16'h5B45, 16'hC678, 16'h39AB,
                            16'h12E7, 16'h34B5, 16'h56D3, 16'h0000};
  logic [13:0] slot_addr [7] = '{14'h0D20, 14'h0D28, 14'h0D30,
                                 14'h0D38, 14'h0D80, 14'h0D84, 14'h0D90};
  row_t        rows [10] = '{
    '{14'h0D20, 32'h0000_F5A5, 4'h3, 32'h0000_F5A5, `TRIM_RESP_OKAY},
    '{14'h0D28, 32'h0000_1234, 4'h3, 32'h0000_1234, `TRIM_RESP_OKAY},
    '{14'h0D30, 32'h0000_0ABC, 4'h3, 32'h0000_0ABC, `TRIM_RESP_OKAY},
    '{14'h0D38, 32'h0000_7FFF, 4'h3, 32'h0000_7FFF, `TRIM_RESP_OKAY},
    '{14'h0D80, 32'h0000_00FF, 4'h1, 32'h0000_00FF, `TRIM_RESP_OKAY},
    '{14'h0D84, 32'h0000_123C, 4'h3, 32'h0000_003C, `TRIM_RESP_OKAY},
    '{14'h0D90, 32'h0000_0015, 4'h1, 32'h0000_0015, `TRIM_RESP_OKAY},
    '{14'h0D20, 32'h0000_9966, 4'h1, 32'h0000_F566, `TRIM_RESP_OKAY},
    '{14'h0D24, 32'h0000_FFFF, 4'h3, 32'h0000_0000, `TRIM_RESP_SLVERR},
    '{14'h0D22, 32'h0000_FFFF, 4'h3, 32'h0000_0000, `TRIM_RESP_SLVERR}};

  core_trim_register_bank i_dut (.*);

  always #2.5 CORE_CLK = ~CORE_CLK;

  // fuse store: requested word next cycle, scrambled when idle
  always @(posedge CORE_CLK)
    FUSE_DATA <= FUSE_REQ.en ? fuse[FUSE_REQ.idx] : ~FUSE_DATA;

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait step
  task automatic tick(inout int n);
    n++;
    if (n > 100) begin
      n_errors++;
      $display("wait ran out at %0t", $time);
      close_out();
    end
  endtask

  task automatic axi_write(input logic [13:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    int   n = 0;
    logic aw_on = 1'b1, w_on = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge CORE_CLK);
      tick(n);
      if (aw_on && S_AXI_AWREADY === 1'b1) begin
        aw_on = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w_on && S_AXI_WREADY === 1'b1) begin
        w_on = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do begin
      @(posedge CORE_CLK);
      tick(n);
    end while (S_AXI_BVALID !== 1'b1);
    // late ready lets the response wait one cycle
    S_AXI_BREADY <= 1'b1;
    @(posedge CORE_CLK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic axi_read(input logic [13:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      tick(n);
    end while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do begin
      @(posedge CORE_CLK);
      tick(n);
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b1;
    @(posedge CORE_CLK);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  // reset, then read requested at once while the load still runs
  task automatic reset_and_reload();
    logic [31:0] d;
    logic [1:0]  r;
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(posedge CORE_CLK);
    check(64'(LOAD_DONE), 64'h0);
    for (int k = 0; k < 7; k++) begin
      axi_read(slot_addr[k], d, r);
      check(64'(d), 64'(fuse[k] & (k < 4 ? 16'hFFFF : 16'h00FF)));
    end
    axi_read(14'h0DC0, d, r);
    check(64'(d), 64'h1);
  endtask

  initial begin
    logic [31:0]                d;
    logic [1:0]                 r;
    trim_bank_pkg::cal_select_t c;
    trim_bank_pkg::trim_apply_t e;
    reset_and_reload();
    $display("reset load test done");
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].d, rows[i].s, r);
      check(64'(r), 64'(rows[i].rs));
      axi_read(rows[i].a, d, r);
      check(64'(d), 64'(rows[i].rd));
      check(64'(r), 64'(rows[i].rs));
    end
    $display("register table test done");
    // every operating point against the values just written
    for (int i = 0; i < 32; i++) begin
      c = trim_bank_pkg::cal_select_t'(i[4:0]);
      CAL_SELECT <= c;
      repeat (2) @(posedge CORE_CLK);
      e.core_a_offset_valid = c.fg_cal_en & c.core_a_quad_phase;
      e.core_a_offset = !e.core_a_offset_valid ? 12'h000 :
                        c.core_a_second_input ? 12'h234 : 12'h566;
      e.core_b_offset_valid = c.fg_cal_en & !c.core_b_quad_phase;
      e.core_b_offset = !e.core_b_offset_valid ? 12'h000 :
                        c.core_b_second_input ? 12'hFFF : 12'hABC;
      e.gain_bank_zero = 5'h1F;
      e.gain_bank_one = 5'h1C;
      e.gain_bank_four = 5'h15;
      check(64'(TRIM_APPLY), 64'(e));
    end
    $display("trim apply test done");
    // software read-modify-write keeps the reserved upper bits
    axi_read(14'h0D28, d, r);
    axi_write(14'h0D28, (d & 32'h0000_F000) | 32'h0000_0ABC, 4'h3, r);
    axi_read(14'h0D28, d, r);
    check(64'(d), 64'h1ABC);
    // status write is ignored with OKAY
    axi_write(14'h0DC0, 32'h0000_0000, 4'h3, r);
    check(64'(r), 64'(`TRIM_RESP_OKAY));
    axi_read(14'h0DC0, d, r);
    check(64'(d), 64'h1);
    $display("read-modify-write test done");
    reset_and_reload();
    $display("mid-run reset test done");
    close_out();
  end
endmodule // core_trim_register_bank_bench
